// [pkg/bcsof_defs.vh]
// Functional notes
// - Value accepted as plain decimal or mantissa with signed exponent, same result.
// - Digits not sent at the tail of a value count as zeros.
// - The value also feeds zero offset and reference junction temperature.
// - After the second calibration point both points go to nonvolatile storage.
// - C0 and C1 calibrate first and second point using latest value.
// - Calibration value above 2200000 counts is rejected with invalid option error.
// - Calibration happens only while the calibration lock switch is unlocked.
// - L0 restores factory settings as power-up state, keeping address and line freq.
// - L1 saves present settings as the power-up state.
// - G0 sends one reading with prefix; buffer location as comma B nnn.
// - G1 sends one reading without prefix; buffer location as comma nnn.
// - G2 to G5 send the whole buffer comma separated with prefix/location options.
// - Power-up, device clear and selected device clear restore default format.
// - B0 takes bus data from converter, B1 from the reading buffer.
// - G0/G1 terminate every reading; G2-G5 terminate only after last entry.
// - Whole-buffer format with converter source sends no terminator.
// - Continuous store size I0 is refused with a high-speed interval.
// - High-speed store needs size 1-500, listed functions, and allowed rate.
`ifndef BCSOF_DEFS_VH
`define BCSOF_DEFS_VH
// ----------------------------------------------------------------
// Value, calibration and storage limits
// ----------------------------------------------------------------
`define BCSOF_FRAC_DIGITS 5
`define BCSOF_MAX_DIGITS 7
`define BCSOF_CAL_LIMIT 32'd2200000
`define BCSOF_SIZE_MAX 10'd500
`define BCSOF_QUEUE_DEPTH 8
// ----------------------------------------------------------------
// Command letters and value/format punctuation (ASCII)
// ----------------------------------------------------------------
`define BCSOF_CH_V 8'h56
`define BCSOF_CH_C 8'h43
`define BCSOF_CH_L 8'h4c
`define BCSOF_CH_G 8'h47
`define BCSOF_CH_B 8'h42
`define BCSOF_CH_X 8'h58
`define BCSOF_CH_E 8'h45
`define BCSOF_CH_DOT 8'h2e
`define BCSOF_CH_PLUS 8'h2b
`define BCSOF_CH_MINUS 8'h2d
`define BCSOF_CH_COMMA 8'h2c
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BCSOF_FMT_RST 3'h0
`define BCSOF_SRC_RST 1'b0
`endif

// [rtl/bcsof_cmd.v]
`timescale 1ns/100ps
`include "bcsof_defs.vh"
module bcsof_cmd
(
  clk,
  rst_n,
  dev_clear,
  rx_valid,
  rx_char,
  cal_unlocked,
  value_out,
  value_valid,
  cal_first_pulse,
  cal_second_pulse,
  cal_commit_pulse,
  invalid_option_error,
  factory_restore_pulse,
  save_setup_pulse,
  fmt_out,
  src_buffer,
  hs_interval,
  store_size,
  function_code,
  rate_code,
  hs_config_ok,
  out_start,
  buf_count,
  rd_loc,
  rd_neg,
  rd_mant,
  rd_exp,
  tx_ready,
  tx_valid,
  tx_char,
  tx_eoi,
  busy
);
input wire clk;
input wire rst_n;
input wire dev_clear;
input wire rx_valid;
input wire [7:0] rx_char;
input wire cal_unlocked;
output reg [31:0] value_out;
output reg value_valid;
output reg cal_first_pulse;
output reg cal_second_pulse;
output reg cal_commit_pulse;
output reg invalid_option_error;
output reg factory_restore_pulse;
output reg save_setup_pulse;
output reg [2:0] fmt_out;
output reg src_buffer;
input wire [2:0] hs_interval;
input wire [9:0] store_size;
input wire [3:0] function_code;
input wire [1:0] rate_code;
output wire hs_config_ok;
input wire out_start;
input wire [9:0] buf_count;
output wire [9:0] rd_loc;
input wire rd_neg;
input wire [27:0] rd_mant;
input wire [3:0] rd_exp;
input wire tx_ready;
output reg tx_valid;
output reg [7:0] tx_char;
output reg tx_eoi;
output wire busy;

// ----------------------------------------------------------------
// High-speed store validity
// ----------------------------------------------------------------
wire hs_sel;
wire size_ok;
wire func_ok;
wire rate_ok;
assign hs_sel = (hs_interval >= 3'd1) && (hs_interval <= 3'd4);
assign size_ok = (store_size != 10'd0) &&
  (store_size <= `BCSOF_SIZE_MAX);
assign func_ok = (function_code == 4'd0) || (function_code == 4'd1) ||
  (function_code == 4'd3) || (function_code == 4'd4) ||
  (function_code == 4'd7) || (function_code == 4'd8);
assign rate_ok = (hs_interval <= 3'd2) ? (rate_code == 2'd0) :
  (rate_code <= 2'd1);
assign hs_config_ok = !hs_sel || (size_ok && func_ok && rate_ok);

// ----------------------------------------------------------------
// Parser: value digits, exponent, command letters
// ----------------------------------------------------------------
localparam P_IDLE = 3'd0;
localparam P_VAL = 3'd1;
localparam P_EXP = 3'd2;
localparam P_ARG = 3'd3;
reg [2:0] p_q;
reg [7:0] let_q;
reg [31:0] mant_q;
reg mneg_q;
reg seen_dot_q;
reg [3:0] frac_q;
reg [3:0] expv_q;
reg eneg_q;
reg [3:0] arg_q;
// Command queue: kind(2) arg(4) value(32)
reg [37:0] q_mem [0:`BCSOF_QUEUE_DEPTH-1];
reg [2:0] wr_q;
reg [2:0] rd_q;
reg [3:0] cnt_q;
reg exec_q;
wire is_dig;
wire [3:0] dig;
assign is_dig = (rx_char >= 8'h30) && (rx_char <= 8'h39);
assign dig = rx_char[3:0];

// Scale mantissa to fixed five fraction digits, unsent digits zero
function [31:0] scale;
  input [31:0] m;
  input [3:0] fr;
  input [3:0] ex;
  input en;
  integer sh;
  integer i;
  reg [31:0] r;
  begin
    sh = `BCSOF_FRAC_DIGITS - fr + (en ? -ex : ex);
    r = m;
    for (i = 0; i < 12; i = i + 1)
    begin
      if (sh > 0)
      begin
        r = r * 32'd10;
        sh = sh - 1;
      end
      else if (sh < 0)
      begin
        r = r / 32'd10;
        sh = sh + 1;
      end
    end
    scale = r;
  end
endfunction

wire [31:0] val_now;
assign val_now = scale(mant_q, frac_q, expv_q, eneg_q);
wire push;
reg [1:0] push_kind;
reg [3:0] push_arg;
wire q_empty;
wire pop;
assign q_empty = (cnt_q == 4'd0);

// Parse one character per strobe, queue completed commands
always @(posedge clk)
begin
  if (!rst_n || dev_clear)
  begin
    p_q <= P_IDLE;
    let_q <= 8'h00;
    mant_q <= 32'h0;
    mneg_q <= 1'b0;
    seen_dot_q <= 1'b0;
    frac_q <= 4'h0;
    expv_q <= 4'h0;
    eneg_q <= 1'b0;
    arg_q <= 4'h0;
    exec_q <= 1'b0;
  end
  else if (rx_valid)
  begin
    exec_q <= (rx_char == `BCSOF_CH_X);
    if (rx_char == `BCSOF_CH_V)
    begin
      p_q <= P_VAL;
      mant_q <= 32'h0;
      mneg_q <= 1'b0;
      seen_dot_q <= 1'b0;
      frac_q <= 4'h0;
      expv_q <= 4'h0;
      eneg_q <= 1'b0;
    end
    else if ((rx_char == `BCSOF_CH_C) || (rx_char == `BCSOF_CH_L) ||
      (rx_char == `BCSOF_CH_G) || (rx_char == `BCSOF_CH_B))
    begin
      p_q <= P_ARG;
      let_q <= rx_char;
      arg_q <= 4'h0;
    end
    else if (p_q == P_VAL)
    begin
      if (is_dig)
      begin
        mant_q <= mant_q * 32'd10 + {28'h0, dig};
        if (seen_dot_q)
          frac_q <= frac_q + 4'd1;
      end
      else if (rx_char == `BCSOF_CH_DOT)
        seen_dot_q <= 1'b1;
      else if (rx_char == `BCSOF_CH_MINUS)
        mneg_q <= 1'b1;
      else if (rx_char == `BCSOF_CH_E)
        p_q <= P_EXP;
      else
        p_q <= P_IDLE;
    end
    else if (p_q == P_EXP)
    begin
      if (is_dig)
        expv_q <= dig;
      else if (rx_char == `BCSOF_CH_MINUS)
        eneg_q <= 1'b1;
      else if (rx_char != `BCSOF_CH_PLUS)
        p_q <= P_IDLE;
    end
    else if ((p_q == P_ARG) && is_dig)
      arg_q <= dig;
    else
      p_q <= P_IDLE;
  end
  else
    exec_q <= 1'b0;
end

// Completed command when a field ends on a new letter or execute
wire field_end;
assign field_end = rx_valid && !is_dig && (rx_char != `BCSOF_CH_DOT) &&
  !((p_q == P_VAL) && ((rx_char == `BCSOF_CH_E) ||
  (rx_char == `BCSOF_CH_MINUS))) &&
  !((p_q == P_EXP) && ((rx_char == `BCSOF_CH_PLUS) ||
  (rx_char == `BCSOF_CH_MINUS)));
always @*
begin
  push_kind = 2'd0;
  push_arg = arg_q;
  if (let_q == `BCSOF_CH_C)
    push_kind = 2'd1;
  else if (let_q == `BCSOF_CH_L)
    push_kind = 2'd2;
  else if (let_q == `BCSOF_CH_G)
    push_kind = 2'd3;
  else
    push_kind = 2'd0;
end
// Value kind 0 uses arg bit 3 for B; B coded as kind 0 arg 8|n
wire push_val;
wire push_arg_cmd;
assign push_val = field_end && ((p_q == P_VAL) || (p_q == P_EXP));
assign push_arg_cmd = field_end && (p_q == P_ARG);
assign push = (push_val || push_arg_cmd) &&
  (cnt_q != `BCSOF_QUEUE_DEPTH);
wire [37:0] push_word;
assign push_word = push_val ?
  {2'd0, 4'h0, mneg_q ? (~val_now + 32'd1) : val_now} :
  (let_q == `BCSOF_CH_B) ? {2'd0, 4'h8 | push_arg, 32'h0} :
  {push_kind, push_arg, 32'h0};

// ----------------------------------------------------------------
// Queue and in-order execution on the execute character
// ----------------------------------------------------------------
reg draining_q;
assign pop = draining_q && !q_empty;
always @(posedge clk)
begin
  if (!rst_n || dev_clear)
  begin
    wr_q <= 3'd0;
    rd_q <= 3'd0;
    cnt_q <= 4'd0;
    draining_q <= 1'b0;
  end
  else
  begin
    if (push)
    begin
      q_mem[wr_q] <= push_word;
      wr_q <= wr_q + 3'd1;
    end
    if (pop)
      rd_q <= rd_q + 3'd1;
    cnt_q <= cnt_q + {3'd0, push} - {3'd0, pop};
    if (exec_q)
      draining_q <= 1'b1;
    else if (q_empty)
      draining_q <= 1'b0;
  end
end

// Execute popped command
wire [37:0] cur;
wire [31:0] cur_abs;
assign cur = q_mem[rd_q];
// Limit applies to the latest value, not to the command word
assign cur_abs = value_out[31] ? (~value_out + 32'd1) : value_out;
reg [1:0] cal_stage_q;
always @(posedge clk)
begin
  cal_first_pulse <= 1'b0;
  cal_second_pulse <= 1'b0;
  cal_commit_pulse <= 1'b0;
  factory_restore_pulse <= 1'b0;
  save_setup_pulse <= 1'b0;
  invalid_option_error <= 1'b0;
  if (!rst_n || dev_clear)
  begin
    fmt_out <= `BCSOF_FMT_RST;
    src_buffer <= `BCSOF_SRC_RST;
    invalid_option_error <= 1'b0;
    if (!rst_n)
    begin
      value_out <= 32'h0;
      value_valid <= 1'b0;
      cal_stage_q <= 2'd0;
    end
  end
  else if (pop)
  begin
    case (cur[37:36])
      2'd0:
      begin
        if (cur[35])
          src_buffer <= cur[32];
        else
        begin
          value_out <= cur[31:0];
          value_valid <= 1'b1;
        end
      end
      2'd1:
      begin
        if (!value_valid || !cal_unlocked || (cur[35:32] > 4'd1) ||
          (cur_abs > `BCSOF_CAL_LIMIT))
          invalid_option_error <= 1'b1;
        else if (cur[32] == 1'b0)
        begin
          cal_first_pulse <= 1'b1;
          cal_stage_q <= 2'd1;
        end
        else
        begin
          cal_second_pulse <= 1'b1;
          cal_commit_pulse <= (cal_stage_q == 2'd1);
          cal_stage_q <= 2'd0;
        end
      end
      2'd2:
      begin
        if (cur[35:32] == 4'd0)
          factory_restore_pulse <= 1'b1;
        else if (cur[35:32] == 4'd1)
          save_setup_pulse <= 1'b1;
        else
          invalid_option_error <= 1'b1;
      end
      default:
      begin
        if (cur[35:32] <= 4'd5)
          fmt_out <= cur[34:32];
        else
          invalid_option_error <= 1'b1;
      end
    endcase
  end
end

// ----------------------------------------------------------------
// Output formatter
// ----------------------------------------------------------------
localparam O_IDLE = 3'd0;
localparam O_PFX = 3'd1;
localparam O_RD = 3'd2;
localparam O_LOC = 3'd3;
localparam O_SEP = 3'd4;
localparam O_TERM = 3'd5;
reg [2:0] o_q;
reg [3:0] idx_q;
reg [9:0] loc_q;
wire src_load;
// Busy covers gaps between bytes, not only held bytes
assign busy = draining_q || tx_valid || (o_q != O_IDLE);
assign src_load = pop && (cur[37:36] == 2'd0) && cur[35];
wire whole;
wire with_pfx;
wire with_loc;
wire last;
assign whole = (fmt_out >= 3'd2);
assign with_pfx = (fmt_out == 3'd0) || (fmt_out == 3'd2) ||
  (fmt_out == 3'd4);
assign with_loc = src_buffer && ((fmt_out <= 3'd3));
assign last = !whole || !src_buffer || (loc_q >= buf_count);
assign rd_loc = loc_q;
reg [7:0] ch;
reg [3:0] ld;
reg [27:0] msh;
wire [9:0] loc_hun;
wire [9:0] loc_ten;
wire [9:0] loc_one;
// Decimal digits of the buffer location
assign loc_hun = loc_q / 10'd100;
assign loc_ten = (loc_q / 10'd10) % 10'd10;
assign loc_one = loc_q % 10'd10;
// Select the character at the present position
always @*
begin
  ch = 8'h20;
  ld = 4'h0;
  msh = rd_mant;
  case (o_q)
    O_PFX: ch = (idx_q == 4'd0) ? 8'h4e : 8'h44;
    O_RD:
    begin
      if (idx_q == 4'd0)
        ch = rd_neg ? `BCSOF_CH_MINUS : `BCSOF_CH_PLUS;
      else if (idx_q == 4'd2)
        ch = `BCSOF_CH_DOT;
      else if (idx_q == 4'd9)
        ch = `BCSOF_CH_E;
      else if (idx_q == 4'd10)
        ch = {4'h3, rd_exp};
      else
      begin
        if (idx_q != 4'd1)
          msh = rd_mant << {idx_q - 4'd2, 2'b00};
        ld = msh[27:24];
        ch = {4'h3, ld};
      end
    end
    O_LOC:
    begin
      if (idx_q == 4'd0)
        ch = `BCSOF_CH_COMMA;
      else if (idx_q == 4'd1)
        ch = `BCSOF_CH_B;
      else if (idx_q == 4'd2)
        ch = {4'h3, loc_hun[3:0]};
      else if (idx_q == 4'd3)
        ch = {4'h3, loc_ten[3:0]};
      else
        ch = {4'h3, loc_one[3:0]};
    end
    O_SEP: ch = `BCSOF_CH_COMMA;
    default: ch = 8'h0a;
  endcase
end

// Step through prefix, reading, location, separator and terminator
always @(posedge clk)
begin
  if (!rst_n || dev_clear)
  begin
    o_q <= O_IDLE;
    idx_q <= 4'd0;
    loc_q <= 10'd1;
    tx_valid <= 1'b0;
    tx_char <= 8'h00;
    tx_eoi <= 1'b0;
  end
  else if (tx_valid && !tx_ready)
    o_q <= o_q;
  else
  begin
    tx_valid <= 1'b0;
    tx_eoi <= 1'b0;
    case (o_q)
      O_IDLE:
      begin
        idx_q <= 4'd0;
        if (out_start && !busy)
        begin
          o_q <= with_pfx ? O_PFX : O_RD;
          if (whole)
            loc_q <= 10'd1;
        end
      end
      O_PFX, O_RD, O_LOC:
      begin
        tx_valid <= 1'b1;
        tx_char <= ch;
        idx_q <= idx_q + 4'd1;
        if ((o_q == O_LOC) && (idx_q == 4'd1) && !with_pfx)
          tx_valid <= 1'b0;
        if ((o_q == O_PFX) && (idx_q == 4'd1))
        begin
          o_q <= O_RD;
          idx_q <= 4'd0;
        end
        else if ((o_q == O_RD) && (idx_q == 4'd10))
        begin
          o_q <= with_loc ? O_LOC : (last ? O_TERM : O_SEP);
          idx_q <= 4'd0;
        end
        else if ((o_q == O_LOC) && (idx_q == 4'd4))
        begin
          o_q <= last ? O_TERM : O_SEP;
          idx_q <= 4'd0;
        end
      end
      O_SEP:
      begin
        tx_valid <= 1'b1;
        tx_char <= ch;
        loc_q <= loc_q + 10'd1;
        o_q <= with_pfx ? O_PFX : O_RD;
      end
      default:
      begin
        tx_valid <= !(whole && !src_buffer);
        tx_eoi <= !(whole && !src_buffer);
        tx_char <= ch;
        if (src_buffer)
          loc_q <= (whole || loc_q >= buf_count) ? 10'd1 : loc_q + 10'd1;
        o_q <= O_IDLE;
      end
    endcase
  end
  // A new source selection restarts at the first buffer location
  if (rst_n && !dev_clear && src_load)
    loc_q <= 10'd1;
end
endmodule // bcsof_cmd

// [dv/bcsof_cmd_assertions.sv]
`timescale 1ns/100ps
`include "bcsof_defs.vh"
module bcsof_chk
(
  input wire clk,
  input wire rst_n,
  input wire dev_clear,
  input wire cal_unlocked,
  input wire [31:0] value_out,
  input wire value_valid,
  input wire cal_first_pulse,
  input wire cal_second_pulse,
  input wire cal_commit_pulse,
  input wire factory_restore_pulse,
  input wire [2:0] fmt_out,
  input wire src_buffer,
  input wire [2:0] hs_interval,
  input wire [9:0] store_size,
  input wire [3:0] function_code,
  input wire [1:0] rate_code,
  input wire hs_config_ok,
  input wire tx_ready,
  input wire tx_valid,
  input wire [7:0] tx_char,
  input wire tx_eoi
);
// ----------------------------------------------------------------
// Helper terms
// ----------------------------------------------------------------
// Magnitude of the value and the expected store check
wire [31:0] mag = value_out[31] ? -value_out : value_out;
wire fn_ok = function_code inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h7, 4'h8};
wire hs_on = hs_interval >= 3'h1 && hs_interval <= 3'h4;
wire rate_ok = hs_interval <= 3'h2 ? rate_code == 2'h0 : rate_code <= 2'h1;
wire size_ok = store_size >= 10'h1 && store_size <= `BCSOF_SIZE_MAX;
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_n);
sequence s_stall;
  tx_valid && !tx_ready;
endsequence
sequence s_held;
  tx_valid && $stable(tx_char) && $stable(tx_eoi);
endsequence
sequence s_cal;
  cal_first_pulse || cal_second_pulse;
endsequence
a_tx_byte_held: assert property (s_stall |=> s_held)
  else $error("tx byte changed while stalled");
a_cal_lock: assert property (s_cal |-> $past(cal_unlocked))
  else $error("calibration while locked");
a_cal_limit: assert property (s_cal |-> value_valid &&
  mag <= `BCSOF_CAL_LIMIT)
  else $error("calibration with bad value");
a_commit_pair: assert property (cal_commit_pulse |-> cal_second_pulse ||
  $past(cal_second_pulse) || $past(cal_second_pulse, 2))
  else $error("commit without second point");
a_first_once: assert property (cal_first_pulse |=> !cal_first_pulse)
  else $error("first point pulse too long");
a_restore_once: assert property (factory_restore_pulse |=>
  !factory_restore_pulse)
  else $error("restore pulse too long");
a_clear_format: assert property (dev_clear |=>
  fmt_out == `BCSOF_FMT_RST && src_buffer == `BCSOF_SRC_RST)
  else $error("format not cleared");
a_eoi_last: assert property (tx_valid && tx_eoi |-> tx_char == 8'h0a)
  else $error("eoi not on terminator");
a_hs_limits: assert property (hs_on |-> hs_config_ok ==
  (size_ok && fn_ok && rate_ok))
  else $error("store config check wrong");
endmodule // bcsof_chk

bind bcsof_cmd bcsof_chk chk_u (.clk(clk), .rst_n(rst_n),
  .dev_clear(dev_clear), .cal_unlocked(cal_unlocked),
  .value_out(value_out), .value_valid(value_valid),
  .cal_first_pulse(cal_first_pulse), .cal_second_pulse(cal_second_pulse),
  .cal_commit_pulse(cal_commit_pulse),
  .factory_restore_pulse(factory_restore_pulse), .fmt_out(fmt_out),
  .src_buffer(src_buffer), .hs_interval(hs_interval),
  .store_size(store_size), .function_code(function_code),
  .rate_code(rate_code), .hs_config_ok(hs_config_ok),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_char(tx_char),
  .tx_eoi(tx_eoi));

// [dv/bcsof_ctl_model.sv]
`timescale 1ns/100ps
module bcsof_ctl_model
(
  input wire clk,
  input wire rst_n,
  input wire clr,
  input wire slow,
  input wire tx_valid,
  input wire [7:0] tx_char,
  input wire tx_eoi,
  output reg tx_ready,
  output integer n_comma,
  output integer n_b,
  output integer n_eoi,
  output reg [7:0] first_c
);
reg [7:0] lfsr_q;
integer n_byte;
// Listener ready, stalls on a pseudo random pattern when slow
always @(posedge clk)
begin
  if (!rst_n)
    lfsr_q <= 8'h5a;
  else
    lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  tx_ready <= !slow || lfsr_q[0];
end
// Counts separators, B location marks and end marks of accepted bytes
always @(posedge clk)
begin
  if (clr)
  begin
    n_byte <= 0;
    n_comma <= 0;
    n_b <= 0;
    n_eoi <= 0;
  end
  else if (tx_valid && tx_ready)
  begin
    n_byte <= n_byte + 1;
    if (n_byte == 0)
      first_c <= tx_char;
    n_comma <= n_comma + (tx_char == 8'h2c);
    n_b <= n_b + (tx_char == 8'h42);
    n_eoi <= n_eoi + tx_eoi;
  end
end
endmodule // bcsof_ctl_model

// [dv/testbench.sv]
`timescale 1ns/100ps
`include "bcsof_defs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
reg clk = 1'b0, rst_n = 1'b0, dev_clear = 1'b0, rx_valid = 1'b0;
reg cal_unlocked = 1'b1, out_start = 1'b0, rd_neg = 1'b0, clr = 1'b1;
reg slow = 1'b0;
reg [7:0] rx_char = 8'h0;
reg [2:0] hs_interval = 3'h0;
reg [9:0] store_size = 10'h0, buf_count = 10'h1;
reg [3:0] function_code = 4'h0, rd_exp = 4'h0;
reg [1:0] rate_code = 2'h0;
reg [27:0] rd_mant = 28'h0;
wire [31:0] value_out;
wire [9:0] rd_loc;
wire [7:0] tx_char;
wire [2:0] fmt_out;
wire value_valid, cal_first_pulse, cal_second_pulse, cal_commit_pulse;
wire invalid_option_error, factory_restore_pulse, save_setup_pulse;
wire src_buffer, hs_config_ok, tx_ready, tx_valid, tx_eoi, busy;
integer errors = 0, cmp_count = 0, seed, i, k, a, b, s, g, n, ev;
integer n_first = 0, n_second = 0, n_commit = 0, n_err = 0;
integer n_fac = 0, n_save = 0, c0, c1, c2, c3, n_comma, n_b, n_eoi;
wire [7:0] first_c;
// ----------------------------------------------------------------
// Design, listener and clock
// ----------------------------------------------------------------
bcsof_cmd dut_u (.clk(clk), .rst_n(rst_n), .dev_clear(dev_clear),
  .rx_valid(rx_valid), .rx_char(rx_char), .cal_unlocked(cal_unlocked),
  .value_out(value_out), .value_valid(value_valid),
  .cal_first_pulse(cal_first_pulse), .cal_second_pulse(cal_second_pulse),
  .cal_commit_pulse(cal_commit_pulse),
  .invalid_option_error(invalid_option_error),
  .factory_restore_pulse(factory_restore_pulse),
  .save_setup_pulse(save_setup_pulse), .fmt_out(fmt_out),
  .src_buffer(src_buffer), .hs_interval(hs_interval),
  .store_size(store_size), .function_code(function_code),
  .rate_code(rate_code), .hs_config_ok(hs_config_ok),
  .out_start(out_start), .buf_count(buf_count), .rd_loc(rd_loc),
  .rd_neg(rd_neg), .rd_mant(rd_mant), .rd_exp(rd_exp),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_char(tx_char),
  .tx_eoi(tx_eoi), .busy(busy));
bcsof_ctl_model model_u (.clk(clk), .rst_n(rst_n), .clr(clr),
  .slow(slow), .tx_valid(tx_valid), .tx_char(tx_char), .tx_eoi(tx_eoi),
  .tx_ready(tx_ready), .n_comma(n_comma), .n_b(n_b), .n_eoi(n_eoi),
  .first_c(first_c));
initial forever #50 clk = ~clk;
// Counts of the one-cycle result pulses
always @(posedge clk)
begin
  n_first <= n_first + (cal_first_pulse === 1'b1);
  n_second <= n_second + (cal_second_pulse === 1'b1);
  n_commit <= n_commit + (cal_commit_pulse === 1'b1);
  n_err <= n_err + (invalid_option_error === 1'b1);
  n_fac <= n_fac + (factory_restore_pulse === 1'b1);
  n_save <= n_save + (save_setup_pulse === 1'b1);
end
// ----------------------------------------------------------------
// Tasks and expectations
// ----------------------------------------------------------------
task summarize;
begin
  $display("compares %0d mismatches %0d", cmp_count, errors);
  if (errors == 0 && cmp_count > 0)
    $display("Regression OK");
  else
    $display("Regression broken");
  $finish;
end
endtask
// Sends a command string, then lets the queue run
task cmd(input string t);
  integer j;
begin
  for (j = 0; j < t.len(); j++)
  begin
    @(negedge clk);
    rx_valid = 1'b1;
    rx_char = t[j];
  end
  @(negedge clk);
  rx_valid = 1'b0;
  repeat (12) @(negedge clk);
end
endtask
// Readings sent: whole buffer only with buffer source
function integer nrd(input integer fg, fs, fn);
  nrd = (fs && fg >= 2) ? fn : 1;
endfunction
function integer exp_commas(input integer fg, fs, fn);
  exp_commas = nrd(fg, fs, fn) - 1 + ((fs && fg < 4) ? nrd(fg, fs, fn) : 0);
endfunction
// Store check: high-speed intervals need size, function and rate
function integer exp_hs(input integer q, z, f, r);
  exp_hs = q < 1 || q > 4 || (z >= 1 && z <= 500 &&
    (f == 0 || f == 1 || f == 3 || f == 4 || f == 7 || f == 8) &&
    (q <= 2 ? r == 0 : r <= 1));
endfunction
function integer exp_b(input integer fg, fs, fn);
  exp_b = (fs && (fg == 0 || fg == 2)) ? nrd(fg, fs, fn) : 0;
endfunction
// ----------------------------------------------------------------
// Tests
// ----------------------------------------------------------------
initial
begin
  seed = 32'h0966;
  repeat (10) @(negedge clk);
  rst_n = 1'b1;
  // Values in both spellings, then a short one
  for (i = 0; i < 6; i++)
  begin
    a = {$random(seed)} % 10;
    b = {$random(seed)} % 10;
    ev = 100000 * (10 * a + b);
    cmd($sformatf("V%0d%0dX", a, b));
    `CHK("plain value", ev, value_out)
    cmd($sformatf("V%0d.%0dE+1X", a, b));
    `CHK("exponent value", ev, value_out)
  end
  cmd("V-2.5X");
  `CHK("short value", -250000, value_out)
  cmd("V25E-1X");
  `CHK("negative exponent", 250000, value_out)
  `CHK("value valid", 1'b1, value_valid)
  $display("test value done");
  // Two point calibration, lock and limit refusals
  c0 = n_first; c1 = n_second; c2 = n_commit; c3 = n_err;
  cmd("V2XC0X");
  cmd("V0XC1X");
  `CHK("second point", 1, n_second - c1)
  `CHK("commit", 1, n_commit - c2)
  cal_unlocked = 1'b0;
  cmd("V2XC0X");
  cal_unlocked = 1'b1;
  cmd("V30XC0X");
  cmd("V22XC0X");
  `CHK("refusals", 2, n_err - c3)
  `CHK("first points", 2, n_first - c0)
  $display("test calibration done");
  c0 = n_fac; c1 = n_save;
  cmd("L0X");
  cmd("L1X");
  `CHK("factory restore", 1, n_fac - c0)
  `CHK("save setup", 1, n_save - c1)
  $display("test defaults done");
  // Queued commands wait for the execute character
  cmd("G5X");
  cmd("G4");
  `CHK("format before execute", 3'h5, fmt_out)
  cmd("G1G3X");
  `CHK("format order", 3'h3, fmt_out)
  cmd("B1G2X");
  `CHK("buffer source", 1'b1, src_buffer)
  dev_clear = 1'b1;
  @(negedge clk);
  dev_clear = 1'b0;
  @(negedge clk);
  `CHK("cleared format", 3'h0, fmt_out)
  `CHK("cleared source", 1'b0, src_buffer)
  $display("test format done");
  // Every format with both sources, listener stalling at random
  for (s = 0; s < 2; s++)
    for (g = 0; g < 6; g++)
    begin
      n = {$random(seed)} % 4 + 1;
      cmd($sformatf("B%0dG%0dX", s, g));
      if (s)
        `CHK("first location", 10'h1, rd_loc)
      buf_count = n;
      slow = $random(seed);
      rd_neg = $random(seed);
      for (k = 0; k < 7; k++)
        rd_mant[4 * k +: 4] = {$random(seed)} % 10;
      rd_exp = {$random(seed)} % 10;
      @(negedge clk);
      clr = 1'b0;
      out_start = 1'b1;
      @(negedge clk);
      out_start = 1'b0;
      repeat (3) @(negedge clk);
      for (k = 0; k < 3000 && busy !== 1'b0; k++)
        @(negedge clk);
      repeat (3) @(negedge clk);
      `CHK("commas", exp_commas(g, s, n), n_comma)
      `CHK("locations", exp_b(g, s, n), n_b)
      `CHK("eoi", (s || g < 2) ? 1 : 0, n_eoi)
      `CHK("prefix", g % 2 == 0, first_c == 8'h4e)
      clr = 1'b1;
      $display("test output B%0d G%0d done", s, g);
    end
  // Store settings at random with the size corners
  for (i = 0; i < 60; i++)
  begin
    hs_interval = i < 2 ? 3'h3 : {$random(seed)} % 5;
    store_size = i == 0 ? 10'h0 : i == 1 ? 10'h1f4 : {$random(seed)} % 512;
    function_code = i < 2 ? 4'h8 : $random(seed);
    rate_code = i < 2 ? 2'h1 : $random(seed);
    @(negedge clk);
    ev = exp_hs(hs_interval, store_size, function_code, rate_code);
    `CHK("store check", ev, hs_config_ok)
  end
  $display("test store done");
  summarize;
end
// Watchdog well beyond the expected run
initial
begin
  #(100 * 60000);
  errors++;
  $display("watchdog expired");
  summarize;
end
endmodule // testbench
